// ### rtl/framer_pkg.sv
package framer_pkg;

  // ----------------------------------------------------------------
  // Frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  START_DELIM    = 8'h7E;
  localparam logic [7:0]  TYPE_UPDATE    = 8'hA0;
  localparam logic [7:0]  TYPE_ROUTE     = 8'hA1;
  localparam logic [7:0]  OPT_NONE       = 8'h00;
  localparam logic [7:0]  OPT_ACKED      = 8'h01;
  localparam logic [7:0]  OPT_BCAST      = 8'h02;
  localparam logic [7:0]  CSUM_BASE      = 8'hFF;
  localparam logic [7:0]  NO_BLOCK       = 8'h00;
  localparam logic [15:0] UPDATE_LEN     = 16'h0016;
  localparam logic [15:0] ROUTE_BASE_LEN = 16'h000D;

  // ----------------------------------------------------------------
  // Byte offsets within a frame
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 6;
  localparam logic [IDX_W-1:0] OFS_START    = 6'h00;
  localparam logic [IDX_W-1:0] OFS_LEN_HI   = 6'h01;
  localparam logic [IDX_W-1:0] OFS_LEN_LO   = 6'h02;
  localparam logic [IDX_W-1:0] OFS_TYPE     = 6'h03;
  localparam logic [IDX_W-1:0] OFS_SRC64    = 6'h04;
  localparam logic [IDX_W-1:0] OFS_NET16    = 6'h0C;
  localparam logic [IDX_W-1:0] OFS_NET16_LO = 6'h0D;
  localparam logic [IDX_W-1:0] OFS_OPTS     = 6'h0E;
  localparam logic [IDX_W-1:0] OFS_MSG      = 6'h0F;
  localparam logic [IDX_W-1:0] OFS_COUNT    = 6'h0F;
  localparam logic [IDX_W-1:0] OFS_BLOCK    = 6'h10;
  localparam logic [IDX_W-1:0] OFS_HOPS     = 6'h10;
  localparam logic [IDX_W-1:0] OFS_TARGET   = 6'h11;
  localparam logic [IDX_W-1:0] TARGET_END   = 6'h19;

  // ----------------------------------------------------------------
  // Hop list sizing
  // ----------------------------------------------------------------
  localparam int unsigned HOP_CNT_W = 4;
  localparam int unsigned MAX_HOPS  = 8;
  localparam logic [HOP_CNT_W-1:0] HOP_LIMIT = 4'h8;

  // ----------------------------------------------------------------
  // Loader wait timing
  // ----------------------------------------------------------------
  localparam int unsigned WAIT_W = 34;
  localparam logic [63:0] CLK_HZ          = 64'd200_000_000;
  localparam logic [63:0] LOADER_WAIT_S   = 64'd75;
  localparam logic [63:0] LOADER_WAIT_CYC = LOADER_WAIT_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    MSG_ACK         = 8'h06,
    MSG_NACK        = 8'h15,
    MSG_NO_LINK_ACK = 8'h40,
    MSG_QUERY       = 8'h51,
    MSG_QUERY_RSP   = 8'h52
  } loader_msg_t;

  typedef enum logic {
    KIND_UPDATE = 1'b0,
    KIND_ROUTE  = 1'b1
  } frame_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } tx_state_t;

  typedef struct packed {
    frame_kind_t                 kind;
    logic [63:0]                 src64;
    logic [15:0]                 net16;
    logic                        acked;
    logic                        bcast;
    loader_msg_t                 msg;
    logic                        block_valid;
    logic [7:0]                  block;
    logic [63:0]                 target64;
    logic [HOP_CNT_W-1:0]        hop_cnt;
    logic [MAX_HOPS-1:0][15:0]   hops;
  } frame_req_t;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Hop count clamped to the list capacity
  function automatic logic [HOP_CNT_W-1:0] hops_used(input frame_req_t r);
    return (r.hop_cnt > HOP_LIMIT) ? HOP_LIMIT : r.hop_cnt;
  endfunction : hops_used

  // Length field: type byte through last data byte
  function automatic logic [15:0] frame_len(input frame_req_t r);
    return (r.kind == KIND_ROUTE) ? ROUTE_BASE_LEN + 16'({hops_used(r), 1'b0}) : UPDATE_LEN;
  endfunction : frame_len

  // Byte p of a 64-bit value, most significant first
  function automatic logic [7:0] pick64(input logic [63:0] v, input logic [2:0] p);
    logic [5:0] sh;
    sh = {~p, 3'b000};
    return v[sh +: 8];
  endfunction : pick64

  // Receive options encoding
  function automatic logic [7:0] opts_byte(input frame_req_t r);
    return r.bcast ? OPT_BCAST : (r.acked ? OPT_ACKED : OPT_NONE);
  endfunction : opts_byte

  // Frame byte at an index, checksum excluded
  function automatic logic [7:0] byte_at(input frame_req_t r, input logic [IDX_W-1:0] idx);
    logic [15:0]      len;
    logic [IDX_W-1:0] rel;
    logic [IDX_W-1:0] trel;
    logic [IDX_W-1:0] hrel;
    logic [7:0]       b;
    len  = frame_len(r);
    rel  = idx - OFS_SRC64;
    trel = idx - OFS_TARGET;
    hrel = idx - OFS_HOPS;
    b    = 8'h00;
    if (idx == OFS_START) b = START_DELIM;
    else if (idx == OFS_LEN_HI) b = len[15:8];
    else if (idx == OFS_LEN_LO) b = len[7:0];
    else if (idx == OFS_TYPE) b = (r.kind == KIND_ROUTE) ? TYPE_ROUTE : TYPE_UPDATE;
    else if (idx < OFS_NET16) b = pick64(r.src64, rel[2:0]);
    else if (idx == OFS_NET16) b = r.net16[15:8];
    else if (idx == OFS_NET16_LO) b = r.net16[7:0];
    else if (idx == OFS_OPTS) b = opts_byte(r);
    else if (r.kind == KIND_UPDATE)
    begin
      if (idx == OFS_MSG) b = r.msg;
      else if (idx == OFS_BLOCK) b = r.block_valid ? r.block : NO_BLOCK;
      else if (idx < TARGET_END) b = pick64(r.target64, trel[2:0]);
    end
    else
    begin
      if (idx == OFS_COUNT) b = 8'(hops_used(r));
      else if (hrel[0] == 1'b0) b = r.hops[hrel[3:1]][15:8];
      else b = r.hops[hrel[3:1]][7:0];
    end
    return b;
  endfunction : byte_at

endpackage : framer_pkg

// ### rtl/loader_watch.sv
// --------------------------------------------------------------------
// Tracks the remote loader state from emitted update status frames
// --------------------------------------------------------------------
module loader_watch #(
  parameter logic [framer_pkg::WAIT_W-1:0] WAIT_CYCLES =
    framer_pkg::LOADER_WAIT_CYC[framer_pkg::WAIT_W-1:0]
) (
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     ev_i,
  input  wire framer_pkg::loader_msg_t  msg_i,
  output logic                          waiting_o,
  output logic                          inactive_o
);

  logic [framer_pkg::WAIT_W-1:0] cnt_q;
  logic                          expire;

  assign expire = waiting_o && (cnt_q == WAIT_CYCLES - 1'b1);

  // Waiting flag: a new message wins over expiry in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) waiting_o <= 1'b0;
    else if (ev_i) waiting_o <= (msg_i == framer_pkg::MSG_NACK);
    else if (expire) waiting_o <= 1'b0;
  end

  // Quiet time counter, restarted by every message
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) cnt_q <= '0;
    else if (ev_i || !waiting_o) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end

  // Inactive loader flag
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) inactive_o <= 1'b0;
    else if (ev_i) inactive_o <= (msg_i == framer_pkg::MSG_QUERY);
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  nack_starts_wait_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ev_i && msg_i == framer_pkg::MSG_NACK |=> waiting_o && cnt_q == '0)
    else $error("NACK did not start the wait");
  wait_expires_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    waiting_o && !ev_i && cnt_q == WAIT_CYCLES - 1'b1 |=> !waiting_o)
    else $error("Wait did not end at the timeout");
  query_inactive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ev_i && msg_i == framer_pkg::MSG_QUERY |=> inactive_o && !waiting_o)
    else $error("Query status did not mark loader inactive");
  timeout_cov_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
    waiting_o ##1 !waiting_o);

endmodule : loader_watch

// ### rtl/status_framer.sv
// --------------------------------------------------------------------
// Update status and route record frame builder
// --------------------------------------------------------------------
module status_framer #(
  parameter logic [framer_pkg::WAIT_W-1:0] WAIT_CYCLES =
    framer_pkg::LOADER_WAIT_CYC[framer_pkg::WAIT_W-1:0]
) (
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    req_valid_i,
  input  wire framer_pkg::frame_req_t  req_i,
  output logic                         req_ready_o,
  output logic [7:0]                   tx_data_o,
  output logic                         tx_valid_o,
  input  wire logic                    tx_ready_i,
  output logic                         loader_waiting_o,
  output logic                         loader_inactive_o
);

  // ------------------------------------------------------------------
  // State and datapath signals
  // ------------------------------------------------------------------
  framer_pkg::tx_state_t           state_q;
  framer_pkg::frame_req_t          req_q;
  logic [framer_pkg::IDX_W-1:0]    cur_q;
  logic [7:0]                      sum_q;
  logic [15:0]                     len_w;
  logic [framer_pkg::IDX_W-1:0]    last_idx;
  logic [framer_pkg::IDX_W-1:0]    nxt_idx;
  logic [7:0]                      sum_next;
  logic [7:0]                      nxt_byte;
  logic                            accept;
  logic                            advance;
  logic                            frame_done;
  logic                            upd_ev;

  // Handshakes and frame bounds
  assign accept     = req_valid_i && req_ready_o;
  assign advance    = tx_valid_o && tx_ready_i;
  assign len_w      = framer_pkg::frame_len(req_q);
  assign last_idx   = framer_pkg::IDX_W'(len_w + 16'(framer_pkg::OFS_TYPE));
  assign frame_done = advance && (state_q == framer_pkg::ST_SEND) && (cur_q == last_idx);
  assign nxt_idx    = cur_q + 1'b1;

  // Running sum over type byte through last data byte
  assign sum_next = (cur_q >= framer_pkg::OFS_TYPE) ? sum_q + tx_data_o : sum_q;

  // Next byte: checksum at the end, field bytes otherwise
  assign nxt_byte = (nxt_idx == last_idx) ? framer_pkg::CSUM_BASE - sum_next
                                          : framer_pkg::byte_at(req_q, nxt_idx);

  // ------------------------------------------------------------------
  // Control
  // ------------------------------------------------------------------
  // Frame sequencer
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) state_q <= framer_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        framer_pkg::ST_IDLE: if (accept) state_q <= framer_pkg::ST_SEND;
        framer_pkg::ST_SEND: if (frame_done) state_q <= framer_pkg::ST_IDLE;
        default:             state_q <= framer_pkg::ST_IDLE;
      endcase
    end
  end

  // Request ready, high only while no frame is in flight
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) req_ready_o <= 1'b1;
    else if (accept) req_ready_o <= 1'b0;
    else if (frame_done) req_ready_o <= 1'b1;
  end

  // Request capture, fields stay fixed for the whole frame
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) req_q <= '0;
    else if (accept) req_q <= req_i;
  end

  // ------------------------------------------------------------------
  // Byte stream
  // ------------------------------------------------------------------
  // Output byte, index and valid
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      cur_q      <= framer_pkg::OFS_START;
    end
    else if (accept)
    begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= framer_pkg::START_DELIM;
      cur_q      <= framer_pkg::OFS_START;
    end
    else if (advance)
    begin
      if (cur_q == last_idx) tx_valid_o <= 1'b0;
      else
      begin
        cur_q     <= nxt_idx;
        tx_data_o <= nxt_byte;
      end
    end
  end

  // Checksum accumulator
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) sum_q <= 8'h00;
    else if (accept) sum_q <= 8'h00;
    else if (advance) sum_q <= sum_next;
  end

  // ------------------------------------------------------------------
  // Loader state tracking
  // ------------------------------------------------------------------
  assign upd_ev = frame_done && (req_q.kind == framer_pkg::KIND_UPDATE);

  loader_watch #(
    .WAIT_CYCLES (WAIT_CYCLES)
  ) u_loader_watch (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .ev_i       (upd_ev),
    .msg_i      (req_q.msg),
    .waiting_o  (loader_waiting_o),
    .inactive_o (loader_inactive_o)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic is_upd;
  logic is_rte;
  assign is_upd = tx_valid_o && (req_q.kind == framer_pkg::KIND_UPDATE);
  assign is_rte = tx_valid_o && (req_q.kind == framer_pkg::KIND_ROUTE);

  start_len_a: assert property (tx_valid_o && cur_q == framer_pkg::OFS_START
    && tx_ready_i |=> tx_data_o == len_w[15:8])
    else $error("Length high byte does not follow the delimiter");
  len_lo_a: assert property (tx_valid_o && cur_q == framer_pkg::OFS_LEN_LO |->
    tx_data_o == len_w[7:0])
    else $error("Length low byte wrong");
  delim_a: assert property (accept |=> tx_valid_o && tx_data_o == framer_pkg::START_DELIM)
    else $error("Frame does not open with the delimiter");
  upd_type_a: assert property (is_upd && cur_q == framer_pkg::OFS_TYPE |->
    tx_data_o == framer_pkg::TYPE_UPDATE)
    else $error("Wrong update frame type");
  rte_type_a: assert property (is_rte && cur_q == framer_pkg::OFS_TYPE |->
    tx_data_o == framer_pkg::TYPE_ROUTE)
    else $error("Wrong route frame type");
  src_msb_a: assert property (tx_valid_o && cur_q == framer_pkg::OFS_SRC64 |->
    tx_data_o == req_q.src64[63:56])
    else $error("Source address not MSB first");
  net_hi_a: assert property (tx_valid_o && cur_q == framer_pkg::OFS_NET16 |->
    tx_data_o == req_q.net16[15:8])
    else $error("Network address high byte wrong");
  net_lo_a: assert property (tx_valid_o && cur_q == framer_pkg::OFS_NET16_LO |->
    tx_data_o == req_q.net16[7:0])
    else $error("Network address low byte wrong");
  opts_a: assert property (tx_valid_o && cur_q == framer_pkg::OFS_OPTS && req_q.bcast |->
    tx_data_o == framer_pkg::OPT_BCAST)
    else $error("Broadcast option not encoded");
  msg_a: assert property (is_upd && cur_q == framer_pkg::OFS_MSG |->
    tx_data_o == req_q.msg)
    else $error("Loader message byte wrong");
  block_a: assert property (is_upd && cur_q == framer_pkg::OFS_BLOCK && !req_q.block_valid
    |-> tx_data_o == framer_pkg::NO_BLOCK)
    else $error("Block byte not zero");
  target_a: assert property (is_upd && cur_q == framer_pkg::OFS_TARGET |->
    tx_data_o == req_q.target64[63:56] && last_idx == framer_pkg::TARGET_END)
    else $error("Target address misplaced");
  count_a: assert property (is_rte && cur_q == framer_pkg::OFS_COUNT |->
    last_idx == framer_pkg::OFS_HOPS + framer_pkg::IDX_W'({tx_data_o[4:0], 1'b0}))
    else $error("Hop count and frame length disagree");
  hop_order_a: assert property (is_rte && cur_q == framer_pkg::OFS_HOPS && tx_ready_i
    && last_idx != framer_pkg::OFS_HOPS |-> tx_data_o == req_q.hops[0][15:8]
    ##1 tx_data_o == req_q.hops[0][7:0])
    else $error("First hop not high byte first");
  csum_a: assert property (tx_valid_o && cur_q == last_idx |->
    tx_data_o == framer_pkg::CSUM_BASE - sum_q)
    else $error("Checksum wrong");
  hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("Byte changed while stalled");
  end_a: assert property (frame_done |=> !tx_valid_o && req_ready_o)
    else $error("Frame did not close");

  // Hop count capacity and sequencer agreement
  hop_cap_a: assert property (is_rte && cur_q == framer_pkg::OFS_COUNT |->
    tx_data_o <= 8'(framer_pkg::HOP_LIMIT))
    else $error("Hop count above list capacity");
  ready_idle_a: assert property (req_ready_o == (state_q == framer_pkg::ST_IDLE))
    else $error("Request ready out of step with the sequencer");

  upd_done_c: cover property (upd_ev);
  rte_hops_c: cover property (frame_done && is_rte && req_q.hop_cnt == 4'h3);
  stall_c: cover property (tx_valid_o && !tx_ready_i ##1 tx_ready_i);

endmodule : status_framer

// ### tb/host_sink.sv
// ----------------------------------------------------------------
// Host side of the byte stream: accepts bytes, stalls on request
// ----------------------------------------------------------------
module host_sink (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic slow_i,
  output logic      ready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] pat_q;

  // Irregular stall pattern while slow, ready every cycle otherwise
  always @(negedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pat_q   <= 8'hA5;
      ready_o <= 1'b0;
    end
    else
    begin
      pat_q   <= {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
      ready_o <= !slow_i || pat_q[0];
    end
  end
endmodule : host_sink

// ### tb/update_and_route_indicator_framer_tb.sv
// ----------------------------------------------------------------
// Self-checking bench for the status frame builder
// ----------------------------------------------------------------
module update_and_route_indicator_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk_i;
  logic                    arst_n;
  logic                    req_valid;
  framer_pkg::frame_req_t  req;
  logic                    req_ready_o;
  logic [7:0]              tx_data_o;
  logic                    tx_valid_o;
  logic                    tx_ready_i;
  logic                    loader_waiting_o;
  logic                    loader_inactive_o;
  logic                    slow;
  logic                    exp_w;
  logic                    exp_i;
  logic [15:0]             lfsr_q;
  logic [7:0]              exp_q[$];
  int                      num_errors;
  int                      n_tests;
  int                      hopn[5] = '{0, 1, 3, 8, 15};
  framer_pkg::loader_msg_t codes[5] = '{framer_pkg::MSG_ACK, framer_pkg::MSG_NACK,
    framer_pkg::MSG_NO_LINK_ACK, framer_pkg::MSG_QUERY, framer_pkg::MSG_QUERY_RSP};

  status_framer #(.WAIT_CYCLES(34'h14)) status_framer_i (
    .clk_i             (clk_i),
    .arst_n_i          (arst_n),
    .req_valid_i       (req_valid),
    .req_i             (req),
    .req_ready_o       (req_ready_o),
    .tx_data_o         (tx_data_o),
    .tx_valid_o        (tx_valid_o),
    .tx_ready_i        (tx_ready_i),
    .loader_waiting_o  (loader_waiting_o),
    .loader_inactive_o (loader_inactive_o)
  );

  host_sink host_sink_i (
    .clk_i    (clk_i),
    .arst_n_i (arst_n),
    .slow_i   (slow),
    .ready_o  (tx_ready_i)
  );

  // Clock at 200 MHz
  initial clk_i = 1'b0;
  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Counts a comparison and reports a mismatch
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : check

  // Next value of the stimulus shift register
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd

  // Request with kind, addresses, block and hops from the shift register, message MSG_QUERY, flags clear
  function automatic framer_pkg::frame_req_t rand_req();
    framer_pkg::frame_req_t r;
    r          = '0;
    r.kind     = rnd() > 16'h8000 ? framer_pkg::KIND_ROUTE : framer_pkg::KIND_UPDATE;
    r.src64    = {rnd(), rnd(), rnd(), rnd()};
    r.target64 = {rnd(), rnd(), rnd(), rnd()};
    r.net16    = rnd();
    r.block    = 8'(rnd());
    r.hop_cnt  = 4'(rnd());
    r.msg      = framer_pkg::MSG_QUERY;
    for (int i = 0; i < 8; i++)
      r.hops[i] = rnd();
    return r;
  endfunction : rand_req

  // Notes the bytes expected for one frame
  function automatic void note(input framer_pkg::frame_req_t r);
    logic [7:0] b[$];
    logic [7:0] s;
    int         n;
    n = (r.hop_cnt > 4'h8) ? 8 : int'(r.hop_cnt);
    b.push_back(r.kind == framer_pkg::KIND_ROUTE ? 8'hA1 : 8'hA0);
    for (int i = 7; i >= 0; i--)
      b.push_back(r.src64[8*i +: 8]);
    b.push_back(r.net16[15:8]);
    b.push_back(r.net16[7:0]);
    b.push_back(r.bcast ? 8'h02 : (r.acked ? 8'h01 : 8'h00));
    if (r.kind == framer_pkg::KIND_UPDATE)
    begin
      b.push_back(r.msg);
      b.push_back(r.block_valid ? r.block : 8'h00);
      for (int i = 7; i >= 0; i--)
        b.push_back(r.target64[8*i +: 8]);
    end
    else
    begin
      b.push_back(8'(n));
      for (int i = 0; i < n; i++)
      begin
        b.push_back(r.hops[i][15:8]);
        b.push_back(r.hops[i][7:0]);
      end
    end
    s = 8'h00;
    foreach (b[i])
      s += b[i];
    b.push_back(8'hFF - s);
    exp_q.push_back(8'h7E);
    exp_q.push_back(8'((b.size() - 1) >> 8));
    exp_q.push_back(8'(b.size() - 1));
    foreach (b[i])
      exp_q.push_back(b[i]);
  endfunction : note

  // Sends one request, then holds other contents up while busy
  task automatic send(input framer_pkg::frame_req_t r);
    int k;
    @(negedge clk_i);
    req_valid = 1'b1;
    req       = r;
    k         = 0;
    while (req_ready_o !== 1'b1 && k < 100)
    begin
      @(negedge clk_i);
      k++;
    end
    note(r);
    @(negedge clk_i);
    check("req_ready busy", 8'h00, 8'(req_ready_o));
    req = rand_req();
    k   = 0;
    while (req_ready_o !== 1'b1 && k < 2000)
    begin
      @(negedge clk_i);
      k++;
    end
    req_valid = 1'b0;
    check("bytes left", 8'h00, 8'(exp_q.size()));
    if (r.kind == framer_pkg::KIND_UPDATE)
    begin
      exp_w = (r.msg == framer_pkg::MSG_NACK);
      exp_i = (r.msg == framer_pkg::MSG_QUERY);
    end
    check("loader_waiting", 8'(exp_w), 8'(loader_waiting_o));
    check("loader_inactive", 8'(exp_i), 8'(loader_inactive_o));
  endtask : send

  // Prints the counts and the verdict, then ends the run
  task automatic results();
    $display("comparisons %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Output watcher: each accepted byte against the oldest note
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (arst_n === 1'b1 && tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
      check("tx_data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, tx_data_o);
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    num_errors++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    framer_pkg::frame_req_t r;
    arst_n     = 1'b0;
    req_valid  = 1'b0;
    req        = '0;
    slow       = 1'b0;
    lfsr_q     = 16'h86A8;
    num_errors = 0;
    n_tests    = 0;
    exp_w      = 1'b0;
    exp_i      = 1'b0;
    repeat (10) @(negedge clk_i);
    check("reset req_ready", 8'h01, 8'(req_ready_o));
    check("reset tx_valid", 8'h00, 8'(tx_valid_o));
    check("reset waiting", 8'h00, 8'(loader_waiting_o));
    check("reset inactive", 8'h00, 8'(loader_inactive_o));
    arst_n = 1'b1;
    // Update frames over every loader code and option mix
    for (int i = 0; i < 10; i++)
    begin
      r             = rand_req();
      r.kind        = framer_pkg::KIND_UPDATE;
      r.msg         = codes[i % 5];
      r.acked       = i[0];
      r.bcast       = i[1];
      r.block_valid = i[2];
      slow          = (i > 4);
      send(r);
    end
    // Route frames from an empty hop list up past the capacity
    for (int j = 0; j < 5; j++)
    begin
      r         = rand_req();
      r.kind    = framer_pkg::KIND_ROUTE;
      r.hop_cnt = 4'(hopn[j]);
      r.acked   = 1'b1;
      slow      = j[0];
      send(r);
    end
    // Negative answer, then quiet until the wait expires
    r      = rand_req();
    r.kind = framer_pkg::KIND_UPDATE;
    r.msg  = framer_pkg::MSG_NACK;
    send(r);
    repeat (15) @(negedge clk_i);
    check("waiting held", 8'h01, 8'(loader_waiting_o));
    repeat (10) @(negedge clk_i);
    check("waiting expired", 8'h00, 8'(loader_waiting_o));
    results();
  end
endmodule : update_and_route_indicator_framer_tb
